// ==== rtl/absp_pkg.sv ====
package absp_pkg;
  // machine cycle is two oscillator cycles; here one sys_clk edge is one
  // oscillator cycle, so a machine-cycle enable fires every second clock
  localparam int unsigned CLKS_PER_MCYCLE = 2;
  localparam int unsigned BIT_BASE_MCYC   = 83;
  localparam int unsigned BIT_STEP_MCYC   = 14;
  localparam int unsigned RATE_STEP_MCYC  = 84;
  localparam logic [15:0] RATE_PRESET     = 16'hfffa;
  localparam logic [3:0]  TX_BIT_COUNT    = 4'hb;
  localparam logic [3:0]  RX_SAMPLE_COUNT = 4'h9;
  localparam logic [15:0] FULL_RESET      = 16'h0157;
  localparam logic [15:0] HALF_RESET      = 16'h012c;
  localparam int unsigned RATE_CNT_W      = 7;

  // bit period in machine cycles from a stored delay parameter
  function automatic logic [23:0] absp_period(input logic [15:0] p);
    logic [15:0] r;
    r = {p[15:8] - 8'h01, p[7:0] - 8'h01};
    return 24'(BIT_BASE_MCYC) + 24'(BIT_STEP_MCYC) * {8'h00, r};
  endfunction

  // increment both bytes separately
  function automatic logic [15:0] absp_bytes_inc(input logic [15:0] v);
    return {v[15:8] + 8'h01, v[7:0] + 8'h01};
  endfunction
endpackage

// ==== rtl/absp_mcyc_div.sv ====
`timescale 1ns/1ns
module absp_mcyc_div
  import absp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      mcyc_en
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       en_next;

  always_comb begin
    if (cnt_reg == 2'(CLKS_PER_MCYCLE - 1)) begin
      cnt_next = 2'h0;
      en_next  = 1'b1;
    end else begin
      cnt_next = cnt_reg + 2'h1;
      en_next  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      mcyc_en <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      mcyc_en <= en_next;
    end
  end
endmodule

// ==== rtl/absp_autobaud_serial.sv ====
`timescale 1ns/1ns
module absp_autobaud_serial
  import absp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       serial_input_pin,
  output logic            serial_output_pin,
  input  wire logic       detect_start,
  input  wire logic       rx_start,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_char,
  output logic            busy,
  output logic            rx_done,
  output logic [7:0]      rx_char,
  output logic            rx_stop_bit,
  output logic            detect_done,
  output logic [15:0]     full_bit_delay,
  output logic [15:0]     half_bit_delay
);
  import absp_pkg::*;

  typedef enum {
    ABSP_IDLE, ABSP_DET_HIGH, ABSP_DET_EDGE, ABSP_DET_LOW,
    ABSP_RX_EDGE, ABSP_RX_BITS, ABSP_TX_BITS
  } absp_state_t;

  logic        mcyc_en;
  absp_state_t state_reg, state_next;
  logic [23:0] tmr_reg, tmr_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [15:0] meas_reg, meas_next;
  logic [8:0]  tx_sh_reg, tx_sh_next;
  logic [6:0]  rstep_reg, rstep_next;
  logic [15:0] full_next, half_next;
  logic [7:0]  rxc_next;
  logic        stop_next, rxd_next, detd_next, so_next, busy_next;

  absp_mcyc_div u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .mcyc_en (mcyc_en)
  );

  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    cnt_next   = cnt_reg;
    meas_next  = meas_reg;
    tx_sh_next = tx_sh_reg;
    rstep_next = rstep_reg;
    full_next  = full_bit_delay;
    half_next  = half_bit_delay;
    rxc_next   = rx_char;
    stop_next  = rx_stop_bit;
    so_next    = serial_output_pin;
    rxd_next   = 1'b0;
    detd_next  = 1'b0;
    unique case (state_reg)
      ABSP_IDLE: begin
        so_next = 1'b1;
        if (detect_start) begin
          state_next = ABSP_DET_HIGH;
        end else if (rx_start) begin
          state_next = ABSP_RX_EDGE;
        end else if (tx_start) begin
          tx_sh_next = {tx_char, 1'b0};
          cnt_next   = TX_BIT_COUNT;
          tmr_next   = absp_period(full_bit_delay);
          so_next    = 1'b0;
          state_next = ABSP_TX_BITS;
        end
      end
      ABSP_DET_HIGH: begin
        if (serial_input_pin) begin
          state_next = ABSP_DET_EDGE;
        end
      end
      ABSP_DET_EDGE: begin
        if (!serial_input_pin) begin
          meas_next  = RATE_PRESET;
          rstep_next = '0;
          state_next = ABSP_DET_LOW;
        end
      end
      ABSP_DET_LOW: begin
        if (serial_input_pin) begin
          full_next  = absp_bytes_inc(meas_reg);
          half_next  = absp_bytes_inc({1'b0, meas_reg[15:1]});
          detd_next  = 1'b1;
          state_next = ABSP_IDLE;
        end else if (mcyc_en) begin
          // count at the start of each window, so a part window still counts
          if (rstep_reg == 7'h00) begin
            meas_next = meas_reg + 16'h0001;
          end
          if (rstep_reg == 7'(RATE_STEP_MCYC - 1)) begin
            rstep_next = '0;
          end else begin
            rstep_next = rstep_reg + 7'h01;
          end
        end
      end
      ABSP_RX_EDGE: begin
        if (!serial_input_pin) begin
          tmr_next   = absp_period(half_bit_delay)
                     + absp_period(full_bit_delay);
          cnt_next   = RX_SAMPLE_COUNT;
          state_next = ABSP_RX_BITS;
        end
      end
      ABSP_RX_BITS: begin
        if (mcyc_en) begin
          if (tmr_reg > 24'h000001) begin
            tmr_next = tmr_reg - 24'h000001;
          end else begin
            cnt_next = cnt_reg - 4'h1;
            tmr_next = absp_period(full_bit_delay);
            if (cnt_reg == 4'h1) begin
              stop_next  = serial_input_pin;
              rxd_next   = 1'b1;
              state_next = ABSP_IDLE;
            end else begin
              rxc_next = {serial_input_pin, rx_char[7:1]};
            end
          end
        end
      end
      ABSP_TX_BITS: begin
        if (mcyc_en) begin
          if (tmr_reg > 24'h000001) begin
            tmr_next = tmr_reg - 24'h000001;
          end else begin
            cnt_next   = cnt_reg - 4'h1;
            tmr_next   = absp_period(full_bit_delay);
            tx_sh_next = {1'b1, tx_sh_reg[8:1]};
            if (cnt_reg == 4'h1) begin
              so_next    = 1'b1;
              state_next = ABSP_IDLE;
            end else begin
              so_next = tx_sh_reg[1];
            end
          end
        end
      end
    endcase
    busy_next = (state_next != ABSP_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= ABSP_IDLE;
      tmr_reg           <= '0;
      cnt_reg           <= '0;
      meas_reg          <= '0;
      tx_sh_reg         <= '1;
      rstep_reg         <= '0;
      full_bit_delay    <= FULL_RESET;
      half_bit_delay    <= HALF_RESET;
      rx_char           <= '0;
      rx_stop_bit       <= 1'b1;
      rx_done           <= 1'b0;
      detect_done       <= 1'b0;
      serial_output_pin <= 1'b1;
      busy              <= 1'b0;
    end else begin
      state_reg         <= state_next;
      tmr_reg           <= tmr_next;
      cnt_reg           <= cnt_next;
      meas_reg          <= meas_next;
      tx_sh_reg         <= tx_sh_next;
      rstep_reg         <= rstep_next;
      full_bit_delay    <= full_next;
      half_bit_delay    <= half_next;
      rx_char           <= rxc_next;
      rx_stop_bit       <= stop_next;
      rx_done           <= rxd_next;
      detect_done       <= detd_next;
      serial_output_pin <= so_next;
      busy              <= busy_next;
    end
  end

  a_idle_line_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ABSP_IDLE) |-> serial_output_pin)
    else $error("line not high while idle");

  a_tx_start_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ABSP_IDLE && !detect_start && !rx_start && tx_start)
      |=> !serial_output_pin && state_reg == ABSP_TX_BITS)
    else $error("start bit not driven low");

  a_rx_first_wait: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ABSP_RX_EDGE && !serial_input_pin)
      |=> tmr_reg == absp_period(half_bit_delay)
                   + absp_period(full_bit_delay))
    else $error("first sample wait wrong");

  a_rx_later_wait: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ABSP_RX_BITS && mcyc_en && tmr_reg <= 24'h000001)
      |=> tmr_reg == absp_period(full_bit_delay))
    else $error("later sample wait wrong");

  a_rx_shift_in: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ABSP_RX_BITS && mcyc_en && tmr_reg <= 24'h000001
      && cnt_reg != 4'h1)
      |=> rx_char[7] == $past(serial_input_pin))
    else $error("sample not shifted into msb");

  a_rx_ninth_done: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rx_done) |-> $past(cnt_reg) == 4'h1 && state_reg == ABSP_IDLE)
    else $error("receive did not end on ninth sample");

  a_det_preset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ABSP_DET_EDGE && !serial_input_pin)
      |=> meas_reg == RATE_PRESET)
    else $error("rate counter not preset");

  a_full_derive: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    detect_done |-> full_bit_delay == absp_bytes_inc($past(meas_reg)))
    else $error("full-bit parameter wrong");

  a_half_derive: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    detect_done |-> half_bit_delay
      == absp_bytes_inc({1'b0, $past(meas_reg[15:1])}))
    else $error("half-bit parameter wrong");

  a_param_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!detect_done && $past(state_reg) != ABSP_DET_LOW)
      |-> $stable(full_bit_delay))
    else $error("parameter changed without detection");
endmodule

// ==== testbench/absp_term_model.sv ====
`timescale 1ns/1ns
module absp_term_model (
  input  wire logic sys_clk,
  output logic      line_out,
  input  wire logic line_in
);
  logic [10:0] got_frame;
  time         t_start;
  initial line_out = 1'b1;
  // one idle bit, start low, data lsb first, stop high; rests high
  task automatic send_char(input logic [7:0] c, input int bit_clks);
    logic [10:0] frame;
    frame = {1'b1, c, 1'b0, 1'b1};
    for (int i = 0; i < 11; i++) begin
      @(negedge sys_clk);
      line_out = frame[i];
      if (i == 1) t_start = $time;
      repeat (bit_clks - 1) @(negedge sys_clk);
    end
  endtask
  // samples mid start, data and both stop periods
  task automatic recv_frame(input int bit_clks);
    @(negedge line_in);
    repeat (bit_clks / 2) @(negedge sys_clk);
    for (int i = 0; i < 11; i++) begin
      got_frame[i] = line_in;
      if (i < 10) repeat (bit_clks) @(negedge sys_clk);
    end
  endtask
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import absp_pkg::*;
  localparam int TERM_CLKS = 334;
  logic        sys_clk;
  logic        rst_n;
  logic        ser_in;
  logic        ser_out;
  logic        detect_start;
  logic        rx_start;
  logic        tx_start;
  logic [7:0]  tx_char;
  logic [7:0]  rx_char;
  logic        busy;
  logic        rx_done;
  logic        rx_stop_bit;
  logic        detect_done;
  logic [15:0] full_bit_delay;
  logic [15:0] half_bit_delay;
  int          fail_count;
  int          compares;
  absp_autobaud_serial dut_u (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .serial_input_pin (ser_in),
    .serial_output_pin(ser_out),
    .detect_start     (detect_start),
    .rx_start         (rx_start),
    .tx_start         (tx_start),
    .tx_char          (tx_char),
    .busy             (busy),
    .rx_done          (rx_done),
    .rx_char          (rx_char),
    .rx_stop_bit      (rx_stop_bit),
    .detect_done      (detect_done),
    .full_bit_delay   (full_bit_delay),
    .half_bit_delay   (half_bit_delay)
  );
  absp_term_model term_u (
    .sys_clk (sys_clk),
    .line_out(ser_in),
    .line_in (ser_out)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // run takes about 43k clocks
  initial begin
    #800000;
    fail_count++;
    stop_test();
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic near(input string what, input int seen, input int exp,
                      input int tol);
    check(what, (seen - exp <= tol && exp - seen <= tol) ? exp : seen, exp);
  endtask
  // clocks per bit, two clocks per machine cycle
  function automatic int bit_clks_of(input logic [15:0] p);
    return 2 * (83 + 14 * ((int'(p[15:8]) - 1) * 256 + int'(p[7:0]) - 1));
  endfunction
  // which: 0 detect, 1 receive, 2 transmit
  task automatic pulse(input int which);
    @(negedge sys_clk);
    {detect_start, rx_start, tx_start} = 3'b100 >> which;
    @(negedge sys_clk);
    {detect_start, rx_start, tx_start} = 3'b000;
  endtask
  task automatic wait_idle(input int limit);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < limit);
    check("idle_wait", n < limit, 1'b1);
  endtask
  task automatic test_tx(input logic [7:0] c);
    int  p;
    time t0;
    p = bit_clks_of(full_bit_delay);
    @(negedge sys_clk);
    tx_char = c;
    fork
      term_u.recv_frame(p);
      begin
        pulse(2);
        t0 = $time;
        repeat (p) @(negedge sys_clk);
        pulse(1);
        wait_idle(30000);
        near("tx_time", int'(($time - t0 + 3) / 8), 11 * p, 3);
      end
    join
    check("tx_frame", term_u.got_frame, {2'b11, c, 1'b0});
    repeat (3) @(posedge sys_clk);
    check("tx_refused", busy, 1'b0);
  endtask
  task automatic test_detect();
    logic [15:0] cnt;
    fork
      term_u.send_char(8'h20, TERM_CLKS);
      begin
        pulse(0);
        wait_idle(20000);
        check("detect_done", detect_done, 1'b1);
      end
    join
    cnt = {full_bit_delay[15:8] - 8'h01, full_bit_delay[7:0] - 8'h01};
    // terminal bit is 167 machine cycles: reduced parameter six
    check("rate_count", cnt, 16'h0006);
    check("full", full_bit_delay, 16'h0107);
    check("half", half_bit_delay, 16'h0104);
  endtask
  task automatic test_rx(input logic [7:0] c);
    int e;
    e = bit_clks_of(half_bit_delay) + 9 * bit_clks_of(full_bit_delay);
    fork
      term_u.send_char(c, TERM_CLKS);
      begin
        pulse(1);
        wait_idle(9000);
        check("rx_done", rx_done, 1'b1);
        check("rx_char", rx_char, c);
        check("rx_stop", rx_stop_bit, 1'b1);
        near("rx_time", int'(($time - term_u.t_start) / 8), e, 4);
      end
    join
  endtask
  initial begin
    rst_n = 1'b0;
    detect_start = 1'b0;
    rx_start = 1'b0;
    tx_start = 1'b0;
    tx_char = 8'h00;
    fail_count = 0;
    compares = 0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    check("full_rst", full_bit_delay, 16'h0157);
    check("half_rst", half_bit_delay, 16'h012c);
    check("out_idle", ser_out, 1'b1);
    test_tx(8'h4e);
    test_detect();
    test_rx(8'h96);
    test_rx(8'h6b);
    test_tx(8'hc3);
    stop_test();
  end
endmodule
